// *** core/pkt_check_pkg.sv ***
// shared constants and types for the packet check-byte link
package pkt_check_pkg;
  // ==========================================================
  // crc engine
  localparam logic [7:0] CRC_POLY_NORMAL = 8'hA6;
  localparam logic [7:0] CRC_POLY_REFL   = 8'hB2;
  localparam logic [7:0] CRC_INIT        = 8'h00;
  localparam logic [7:0] CRC_ZERO        = 8'h00;
  // ==========================================================
  // framing
  localparam int BYTE_BITS     = 8;
  localparam int MAX_CMD_BITS  = 247;
  localparam int MIN_HAMMING   = 6;
  localparam logic [7:0] ADDR_AFTER_RESET = 8'h00;
  localparam logic [2:0] BIT_CNT_RESET    = 3'h0;
  localparam logic [2:0] BIT_CNT_LAST     = 3'h7;
  // ==========================================================
  // byte kinds on the link
  typedef enum logic [1:0] {
    KIND_DATA,
    KIND_ALIVE,
    KIND_CHECK
  } byte_kind_e;

  // one lsb-first step of the reflected crc register
  function automatic logic [7:0] crc_step(input logic [7:0] crc,
                                          input logic       din);
    logic fb;
    fb = crc[0] ^ din;
    crc_step = fb ? ((crc >> 1) ^ CRC_POLY_REFL) : (crc >> 1);
  endfunction
endpackage

// *** core/pkt_link_if.sv ***
// serial link between host and device, one bit per strobe
`timescale 1ns/1ps
interface pkt_link_if;
  import pkt_check_pkg::*;
  // host to device
  logic       dn_valid;
  logic       dn_bit;
  logic       dn_start;
  logic       dn_check;
  logic       dn_alive;
  logic       dn_path_down;
  logic       dn_is_write;
  // device to host
  logic       up_valid;
  logic       up_bit;
  logic       up_start;
  logic       up_check;

  modport dev (
    input  dn_valid, dn_bit, dn_start, dn_check, dn_alive, dn_path_down,
           dn_is_write,
    output up_valid, up_bit, up_start, up_check
  );
  modport host (
    output dn_valid, dn_bit, dn_start, dn_check, dn_alive, dn_path_down,
           dn_is_write,
    input  up_valid, up_bit, up_start, up_check
  );
endinterface

// *** core/pkt_check_dev.sv ***
// device end: check incoming packets and sign outgoing read data
//
`timescale 1ns/1ps
// Function
// - crc-8 polynomial a6 on both ends
// - stream enters crc lsb first
// - clear crc before each packet
// - check byte bit n equals remainder bit n
// - compare received check byte, execute on match
// - discard write on mismatch, registers untouched
// - mismatch sets path flag and summary flag
// - single uart reports mismatches on up path
// - dual uart selects up or down flag
// - outgoing data followed by its remainder
// - host appends check byte to every transaction
// - host may compare remainder to check byte
// - host may expect zero remainder instead
// - address zero and undetected mode after reset
// - host reinitialises chain after every reset
// - read commands carry a data-check byte
// - check byte gives distance six framing
// - host reads back written registers; bench sends no read-back after writes
// - reflected constant b2 xored on feedback
// - check and alive bytes excluded from crc
module pkt_check_dev (
  input  wire logic        clk,
  input  wire logic        reset,
  pkt_link_if.dev          link,
  input  wire logic        dual_uart,
  input  wire logic        tx_start,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_last,
  input  wire logic        status_clear,
  output logic             tx_ready,
  output logic             write_commit,
  output logic             write_discard,
  output logic             rx_accept,
  output logic             check_error_up_path_flag,
  output logic             check_error_down_path_flag,
  output logic             check_error_summary_flag,
  output logic [7:0]       dev_address,
  output logic             mode_detected
);
  import pkt_check_pkg::*;

  // ==========================================================
  // receive side
  logic [7:0] rx_crc_r;
  logic [7:0] rx_chk_r;
  logic [2:0] rx_cnt_r;
  logic       rx_write_pend_r;
  logic       rx_path_dn_r;
  logic       rx_done;
  logic       err_pulse;

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_crc_r <= CRC_INIT;
    end else if (link.dn_valid && link.dn_start) begin
      rx_crc_r <= crc_step(CRC_INIT, link.dn_bit);
    end else if (link.dn_valid && !link.dn_check && !link.dn_alive) begin
      rx_crc_r <= crc_step(rx_crc_r, link.dn_bit);
    end
  end

  // check byte gathered lsb first into its own shift register
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_chk_r <= CRC_ZERO;
      rx_cnt_r <= BIT_CNT_RESET;
    end else if (link.dn_valid && link.dn_start) begin
      rx_cnt_r <= BIT_CNT_RESET;
    end else if (link.dn_valid && link.dn_check) begin
      rx_chk_r <= {link.dn_bit, rx_chk_r[7:1]};
      rx_cnt_r <= rx_cnt_r + 3'h1;
    end
  end

  assign rx_done = link.dn_valid && link.dn_check && !link.dn_start &&
                   (rx_cnt_r == BIT_CNT_LAST);

  // pending write latched with the packet start
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_write_pend_r <= 1'b0;
      rx_path_dn_r    <= 1'b0;
    end else if (link.dn_valid && link.dn_start) begin
      rx_write_pend_r <= link.dn_is_write;
      rx_path_dn_r    <= link.dn_path_down;
    end else if (rx_done) begin
      rx_write_pend_r <= 1'b0;
    end
  end

  // last check bit is merged in here so the compare sees the full byte
  logic match;
  assign match = ({link.dn_bit, rx_chk_r[7:1]} == rx_crc_r);
  assign err_pulse = rx_done && !match;

  always_ff @(posedge clk) begin
    if (reset) begin
      write_commit  <= 1'b0;
      write_discard <= 1'b0;
      rx_accept     <= 1'b0;
    end else begin
      write_commit  <= rx_done && match && rx_write_pend_r;
      write_discard <= err_pulse && rx_write_pend_r;
      rx_accept     <= rx_done && match;
    end
  end

  // ==========================================================
  // error flags: set wins over clear
  logic use_dn;
  assign use_dn = dual_uart && rx_path_dn_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      check_error_up_path_flag   <= 1'b0;
      check_error_down_path_flag <= 1'b0;
      check_error_summary_flag   <= 1'b0;
    end else begin
      check_error_up_path_flag <= (err_pulse && !use_dn) ||
        (check_error_up_path_flag && !status_clear);
      check_error_down_path_flag <= (err_pulse && use_dn) ||
        (check_error_down_path_flag && !status_clear);
      check_error_summary_flag <= err_pulse ||
        (check_error_summary_flag && !status_clear);
    end
  end

  // ==========================================================
  // post-reset addressing state
  always_ff @(posedge clk) begin
    if (reset) begin
      dev_address   <= ADDR_AFTER_RESET;
      mode_detected <= 1'b0;
    end else if (link.dn_valid) begin
      mode_detected <= 1'b1;
    end
  end

  // ==========================================================
  // transmit side: data bytes serialised, then the remainder
  typedef enum {TX_IDLE, TX_DATA, TX_CHECK} tx_state_e;
  tx_state_e  tx_state_r;
  logic [7:0] tx_sh_r;
  logic [7:0] tx_crc_r;
  logic [2:0] tx_cnt_r;
  logic       tx_last_r;
  logic       tx_first_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_state_r <= TX_IDLE;
      tx_sh_r    <= 8'h00;
      tx_crc_r   <= CRC_INIT;
      tx_cnt_r   <= BIT_CNT_RESET;
      tx_last_r  <= 1'b0;
      tx_first_r <= 1'b0;
      tx_ready   <= 1'b0;
    end else begin
      case (tx_state_r)
        TX_IDLE: begin
          tx_ready <= 1'b0;
          if (tx_start) begin
            tx_crc_r   <= CRC_INIT;
            tx_first_r <= 1'b1;
            tx_ready   <= 1'b1;
          end
          if (tx_valid && tx_ready) begin
            tx_sh_r    <= tx_byte;
            tx_last_r  <= tx_last;
            tx_cnt_r   <= BIT_CNT_RESET;
            tx_ready   <= 1'b0;
            tx_state_r <= TX_DATA;
          end
        end
        TX_DATA: begin
          tx_first_r <= 1'b0;
          tx_crc_r   <= crc_step(tx_crc_r, tx_sh_r[0]);
          tx_sh_r    <= tx_sh_r >> 1;
          tx_cnt_r   <= tx_cnt_r + 3'h1;
          if (tx_cnt_r == BIT_CNT_LAST) begin
            if (tx_last_r) begin
              tx_state_r <= TX_CHECK;
            end else begin
              tx_ready   <= 1'b1;
              tx_state_r <= TX_IDLE;
            end
          end
        end
        TX_CHECK: begin
          // remainder shifts out lsb first right after the data
          tx_crc_r <= tx_crc_r >> 1;
          tx_cnt_r <= tx_cnt_r + 3'h1;
          if (tx_cnt_r == BIT_CNT_LAST) begin
            tx_state_r <= TX_IDLE;
          end
        end
        default: tx_state_r <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      link.up_valid <= 1'b0;
      link.up_bit   <= 1'b0;
      link.up_start <= 1'b0;
      link.up_check <= 1'b0;
    end else begin
      link.up_valid <= tx_state_r != TX_IDLE;
      link.up_bit   <= (tx_state_r == TX_CHECK) ? tx_crc_r[0] : tx_sh_r[0];
      link.up_start <= (tx_state_r == TX_DATA) && tx_first_r;
      link.up_check <= tx_state_r == TX_CHECK;
    end
  end
endmodule

// *** core/pkt_check_host.sv ***
// host end: sign outgoing commands and validate returned data
`timescale 1ns/1ps
module pkt_check_host (
  input  wire logic        clk,
  input  wire logic        reset,
  pkt_link_if.host         link,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic        cmd_first,
  input  wire logic        cmd_last,
  input  wire logic        cmd_alive,
  input  wire logic        cmd_write,
  input  wire logic        cmd_path_down,
  input  wire logic        zero_method,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic             rsp_good,
  output logic [7:0]       rsp_remainder
);
  import pkt_check_pkg::*;

  // ==========================================================
  // command side: bytes serialised lsb first, check byte appended
  typedef enum {H_IDLE, H_DATA, H_CHECK} h_state_e;
  h_state_e   st_r;
  logic [7:0] sh_r;
  logic [7:0] crc_r;
  logic [2:0] cnt_r;
  logic       last_r;
  logic       alive_r;
  logic       first_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r      <= H_IDLE;
      sh_r      <= 8'h00;
      crc_r     <= CRC_INIT;
      cnt_r     <= BIT_CNT_RESET;
      last_r    <= 1'b0;
      alive_r   <= 1'b0;
      first_r   <= 1'b0;
      cmd_ready <= 1'b1;
    end else begin
      case (st_r)
        H_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            sh_r      <= cmd_byte;
            last_r    <= cmd_last;
            alive_r   <= cmd_alive;
            first_r   <= cmd_first;
            cnt_r     <= BIT_CNT_RESET;
            cmd_ready <= 1'b0;
            if (cmd_first) begin
              crc_r <= CRC_INIT;
            end
            st_r <= H_DATA;
          end
        end
        H_DATA: begin
          first_r <= 1'b0;
          if (!alive_r) begin
            // alive counter travels but stays out of the crc
            // crc_r was cleared when the first byte was taken
            crc_r <= crc_step(crc_r, sh_r[0]);
          end
          sh_r  <= sh_r >> 1;
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == BIT_CNT_LAST) begin
            if (last_r) begin
              st_r <= H_CHECK;
            end else begin
              cmd_ready <= 1'b1;
              st_r      <= H_IDLE;
            end
          end
        end
        H_CHECK: begin
          crc_r <= crc_r >> 1;
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == BIT_CNT_LAST) begin
            cmd_ready <= 1'b1;
            st_r      <= H_IDLE;
          end
        end
        default: st_r <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      link.dn_valid     <= 1'b0;
      link.dn_bit       <= 1'b0;
      link.dn_start     <= 1'b0;
      link.dn_check     <= 1'b0;
      link.dn_alive     <= 1'b0;
      link.dn_path_down <= 1'b0;
      link.dn_is_write  <= 1'b0;
    end else begin
      link.dn_valid <= st_r != H_IDLE;
      link.dn_bit   <= (st_r == H_CHECK) ? crc_r[0] : sh_r[0];
      link.dn_start <= (st_r == H_DATA) && first_r;
      link.dn_check <= st_r == H_CHECK;
      link.dn_alive <= (st_r == H_DATA) && alive_r;
      if (cmd_valid && cmd_ready && cmd_first) begin
        link.dn_path_down <= cmd_path_down;
        link.dn_is_write  <= cmd_write;
      end
    end
  end

  // ==========================================================
  // response side
  logic [7:0] r_crc_r;
  logic [7:0] r_chk_r;
  logic [2:0] r_cnt_r;
  logic [7:0] full_chk;
  logic [7:0] zero_crc;

  always_ff @(posedge clk) begin
    if (reset) begin
      r_crc_r <= CRC_INIT;
      r_chk_r <= CRC_ZERO;
      r_cnt_r <= BIT_CNT_RESET;
    end else if (link.up_valid && link.up_start) begin
      r_crc_r <= crc_step(CRC_INIT, link.up_bit);
      r_cnt_r <= BIT_CNT_RESET;
    end else if (link.up_valid && !link.up_check) begin
      r_crc_r <= crc_step(r_crc_r, link.up_bit);
    end else if (link.up_valid && link.up_check) begin
      r_chk_r <= {link.up_bit, r_chk_r[7:1]};
      r_cnt_r <= r_cnt_r + 3'h1;
    end
  end

  // zero method keeps shifting the check byte through a copy of the engine
  always_comb begin
    full_chk = {link.up_bit, r_chk_r[7:1]};
    zero_crc = r_crc_r;
    for (int i = 0; i < BYTE_BITS; i++) begin
      zero_crc = crc_step(zero_crc, full_chk[i]);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      rsp_valid     <= 1'b0;
      rsp_good      <= 1'b0;
      rsp_remainder <= CRC_ZERO;
    end else begin
      rsp_valid <= link.up_valid && link.up_check &&
                   (r_cnt_r == BIT_CNT_LAST);
      if (link.up_valid && link.up_check && (r_cnt_r == BIT_CNT_LAST)) begin
        rsp_remainder <= zero_method ? zero_crc : r_crc_r;
        rsp_good <= zero_method ? (zero_crc == CRC_ZERO)
                                : (full_chk == r_crc_r);
      end
    end
  end
endmodule

// *** testbench/pkt_link_properties.sv ***
// wire-level properties of the host and device packet link: crc, length and start both directions, follow and idle down only
`timescale 1ns/1ps
module pkt_link_properties (
  input wire logic clk,
  input wire logic reset,
  input wire logic dn_valid,
  input wire logic dn_bit,
  input wire logic dn_start,
  input wire logic dn_check,
  input wire logic dn_alive,
  input wire logic up_valid,
  input wire logic up_bit,
  input wire logic up_start,
  input wire logic up_check
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ====================================================
  // reference remainders, kept apart from the design
  logic [7:0] dcrc_r;
  logic [7:0] ucrc_r;
  logic [2:0] didx_r;
  logic [2:0] uidx_r;
  function automatic logic [7:0] stp(input logic [7:0] c, input logic b);
    stp = (c[0] ^ b) ? ((c >> 1) ^ 8'hB2) : (c >> 1);
  endfunction
  always_ff @(posedge clk) begin
    if (reset) begin
      dcrc_r <= 8'h00;
      didx_r <= 3'h0;
    end else if (dn_valid && dn_check) begin
      didx_r <= didx_r + 3'h1;
    end else if (dn_valid && !dn_alive) begin
      dcrc_r <= stp(dn_start ? 8'h00 : dcrc_r, dn_bit);
    end
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      ucrc_r <= 8'h00;
      uidx_r <= 3'h0;
    end else if (up_valid && up_check) begin
      uidx_r <= uidx_r + 3'h1;
    end else if (up_valid) begin
      ucrc_r <= stp(up_start ? 8'h00 : ucrc_r, up_bit);
    end
  end
  // ====================================================
  // assertions
  property p_dn_crc; dn_valid && dn_check |-> dn_bit == dcrc_r[didx_r];
  endproperty
  a_dn_crc: assert property (p_dn_crc)
    else $error("down check bit differs from remainder");
  property p_up_crc; up_valid && up_check |-> up_bit == ucrc_r[uidx_r];
  endproperty
  a_up_crc: assert property (p_up_crc)
    else $error("up check bit differs from remainder");
  property p_dn_len;
    $rose(dn_check) |-> (dn_valid && dn_check)[*8] ##1 !dn_check;
  endproperty
  a_dn_len: assert property (p_dn_len)
    else $error("down check byte not eight bits");
  property p_up_len;
    $rose(up_check) |-> (up_valid && up_check)[*8] ##1 !up_check;
  endproperty
  a_up_len: assert property (p_up_len)
    else $error("up check byte not eight bits");
  property p_dn_start; dn_start |-> dn_valid && !dn_check; endproperty
  a_dn_start: assert property (p_dn_start)
    else $error("down start outside data");
  property p_up_start; up_start |-> up_valid && !up_check; endproperty
  a_up_start: assert property (p_up_start)
    else $error("up start outside data");
  property p_dn_follow; $rose(dn_check) |-> $past(dn_valid); endproperty
  a_dn_follow: assert property (p_dn_follow)
    else $error("check byte not right after data");
  property p_dn_idle; !dn_valid |-> !dn_check && !dn_start; endproperty
  a_dn_idle: assert property (p_dn_idle)
    else $error("framing flag without bit strobe");
endmodule

// *** testbench/tb.sv ***
// self-checking bench: host and device ends face each other
`timescale 1ns/1ps
module tb;
  import pkt_check_pkg::*;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic       cmd_valid, cmd_first, cmd_last, cmd_alive, cmd_write, cmd_down;
  logic       zero_method, dual_uart, dual_b, clr, tx_start, tx_valid;
  logic       tx_last, cmd_ready, tx_ready, rsp_valid, rsp_good, mode_det;
  logic [7:0] cmd_byte, tx_byte, rsp_rem, addr, lfsr_r, dn_sh, up_sh;
  wire  [5:0] ra, rb;
  logic [7:0] q[$];
  int         errors = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  pkt_link_if link_a ();
  pkt_link_if link_b ();
  pkt_check_host pkt_check_host_i (.clk(clk), .reset(reset),
    .link(link_a.host), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
    .cmd_first(cmd_first), .cmd_last(cmd_last), .cmd_alive(cmd_alive),
    .cmd_write(cmd_write), .cmd_path_down(cmd_down),
    .zero_method(zero_method), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_good(rsp_good), .rsp_remainder(rsp_rem));
  pkt_check_dev pkt_check_dev_i (.clk(clk), .reset(reset),
    .link(link_a.dev), .dual_uart(dual_uart), .tx_start(tx_start),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_last(tx_last),
    .status_clear(clr), .tx_ready(tx_ready), .write_commit(ra[0]),
    .write_discard(ra[1]), .rx_accept(ra[2]),
    .check_error_up_path_flag(ra[3]), .check_error_down_path_flag(ra[4]),
    .check_error_summary_flag(ra[5]), .dev_address(addr),
    .mode_detected(mode_det));
  // second device sees a bench driver that can corrupt the check byte
  pkt_check_dev pkt_check_dev_b_i (.clk(clk), .reset(reset),
    .link(link_b.dev), .dual_uart(dual_b), .tx_start(1'b0),
    .tx_valid(1'b0), .tx_byte(8'h00), .tx_last(1'b0),
    .status_clear(clr), .tx_ready(), .write_commit(rb[0]),
    .write_discard(rb[1]), .rx_accept(rb[2]),
    .check_error_up_path_flag(rb[3]), .check_error_down_path_flag(rb[4]),
    .check_error_summary_flag(rb[5]), .dev_address(),
    .mode_detected());
  pkt_link_properties pkt_link_properties_i (.clk(clk), .reset(reset),
    .dn_valid(link_a.dn_valid), .dn_bit(link_a.dn_bit),
    .dn_start(link_a.dn_start), .dn_check(link_a.dn_check),
    .dn_alive(link_a.dn_alive), .up_valid(link_a.up_valid),
    .up_bit(link_a.up_bit), .up_start(link_a.up_start),
    .up_check(link_a.up_check));
  // ====================================================
  // clock, timeout and wire shifters
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      test_done();
    end
  end
  always @(posedge clk) begin
    if (link_a.dn_valid === 1'b1) dn_sh <= {link_a.dn_bit, dn_sh[7:1]};
    if (link_a.up_valid === 1'b1) up_sh <= {link_a.up_bit, up_sh[7:1]};
  end
  // ====================================================
  // model and tasks
  function automatic logic [7:0] lfsr_next(input logic [7:0] v);
    lfsr_next = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [7:0] crc_of(input int skip);
    logic [7:0] c;
    c = CRC_INIT;
    foreach (q[i]) begin
      if (i != skip) begin
        c = c ^ q[i];
        for (int k = 0; k < 8; k++)
          c = c[0] ? ((c >> 1) ^ CRC_POLY_REFL) : (c >> 1);
      end
    end
    crc_of = c;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rand_q(input int n);
    q.delete();
    repeat (n) begin
      lfsr_r = lfsr_next(lfsr_r);
      q.push_back(lfsr_r);
    end
  endtask
  task automatic host_send(input int skip, input logic wr, input logic dn);
    foreach (q[i]) begin
      cmd_valid <= 1'b1;
      cmd_byte  <= q[i];
      cmd_first <= (i == 0);
      cmd_last  <= (i == q.size() - 1);
      cmd_alive <= (i == skip);
      cmd_write <= wr;
      cmd_down  <= dn;
      @(posedge clk);
      for (int n = 0; n < 40 && cmd_ready !== 1'b1; n++) @(posedge clk);
    end
    cmd_valid <= 1'b0;
  endtask
  task automatic dev_tx();
    tx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    foreach (q[i]) begin
      tx_valid <= 1'b1;
      tx_byte  <= q[i];
      tx_last  <= (i == q.size() - 1);
      @(posedge clk);
      for (int n = 0; n < 40 && tx_ready !== 1'b1; n++) @(posedge clk);
    end
    tx_valid <= 1'b0;
  endtask
  // released data line shows the inverse so a stale bit never reads valid
  task automatic bad_send(input logic wr, input logic dn,
                          input logic [7:0] flip);
    q.push_back(crc_of(-1) ^ flip);
    foreach (q[i]) for (int k = 0; k < 8; k++) begin
      link_b.dn_valid     <= 1'b1;
      link_b.dn_bit       <= q[i][k];
      link_b.dn_start     <= (i == 0 && k == 0);
      link_b.dn_check     <= (i == q.size() - 1);
      link_b.dn_path_down <= dn;
      link_b.dn_is_write  <= wr;
      @(posedge clk);
    end
    link_b.dn_valid <= 1'b0;
    link_b.dn_check <= 1'b0;
    link_b.dn_bit   <= ~q[q.size() - 1][7];
  endtask
  // r = {summary, down, up, accept, discard, commit}
  task automatic expect_dev(input bit b, input logic [5:0] exp);
    logic [5:0] r;
    r = 6'h00;
    for (int n = 0; n < 60; n++) begin
      @(posedge clk);
      r = b ? rb : ra;
      if (r[2:0] !== 3'h0) break;
    end
    chk({5'h00, r[2:0]}, {5'h00, exp[2:0]});
    repeat (2) @(posedge clk);
    r = b ? rb : ra;
    chk({5'h00, r[5:3]}, {5'h00, exp[5:3]});
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ====================================================
  // main sequence
  initial begin
    {cmd_valid, cmd_first, cmd_last, cmd_alive, cmd_write} = 5'h00;
    {cmd_down, zero_method, dual_uart, dual_b, clr} = 5'h00;
    {tx_start, tx_valid, tx_last, cmd_byte, tx_byte} = 19'h00000;
    {link_b.dn_valid, link_b.dn_bit, link_b.dn_start} = 3'h0;
    {link_b.dn_check, link_b.dn_alive, link_b.dn_path_down} = 3'h0;
    link_b.dn_is_write = 1'b0;
    lfsr_r = 8'h08;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk(addr, ADDR_AFTER_RESET);
    chk({7'h00, mode_det}, 8'h00);
    chk({7'h00, cmd_ready}, 8'h01);
    $display("test reset done");
    for (int t = 0; t < 6; t++) begin
      rand_q(t + 1);
      dual_uart <= t[2];
      host_send(t > 2 ? 1 : -1, t[0], t[1]);
      expect_dev(1'b0, {3'b000, 1'b1, 1'b0, t[0]});
      chk(dn_sh, crc_of(t > 2 ? 1 : -1));
    end
    chk({7'h00, mode_det}, 8'h01);
    $display("test command done");
    for (int z = 0; z < 2; z++) begin
      zero_method <= z[0];
      rand_q(3 + z);
      dev_tx();
      for (int n = 0; n < 200 && rsp_valid !== 1'b1; n++) @(posedge clk);
      chk({7'h00, rsp_good}, 8'h01);
      chk(rsp_rem, z[0] ? CRC_ZERO : crc_of(-1));
      chk(up_sh, crc_of(-1));
      @(posedge clk);
    end
    $display("test response done");
    // flip stands for a line fault that the far end cannot make itself
    for (int m = 0; m < 16; m++) begin
      dual_b <= m[2];
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      rand_q(2);
      bad_send(m[3], m[1], m[0] ? (lfsr_r | 8'h01) : 8'h00);
      expect_dev(1'b1, {m[0], m[0] & m[2] & m[1], m[0] & ~(m[2] & m[1]),
                        ~m[0], m[0] & m[3], ~m[0] & m[3]});
    end
    $display("test mismatch done");
    // mid-run reset: the host starts over and the chain must answer again
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk({2'h0, rb}, 8'h00);
    chk({7'h00, mode_det}, 8'h00);
    chk(addr, ADDR_AFTER_RESET);
    rand_q(2);
    host_send(-1, 1'b1, 1'b0);
    expect_dev(1'b0, 6'h05);
    chk(dn_sh, crc_of(-1));
    $display("test reinit done");
    test_done();
  end
endmodule
